/* logic/serial_link_status_and_frame_char.sv */
// Link status, frame character and channel power-down register bank
// ==========================================================
`timescale 1ns/10ps
`default_nettype none
`include "serial_link_status_consts.svh"
module serial_link_status_and_frame_char (
  // Clock and reset
  input  wire logic                 i_clk,
  input  wire logic                 i_arst_n,
  // Register port
  input  wire logic [`ADDR_W-1:0]   i_addr,
  input  wire logic [7:0]           i_wdata,
  input  wire logic                 i_wr,
  input  wire logic                 i_rd,
  output logic [7:0]                o_rdata,
  // Link state from pins and link logic
  input  wire logic                 i_sync_n,
  input  wire logic                 i_pll_locked,
  input  wire logic                 i_link_up,
  input  wire logic                 i_sysref_realign,
  input  wire logic                 i_sysref_event,
  // Transmit octet stream
  input  wire logic [7:0]           i_tx_data,
  input  wire logic                 i_tx_valid,
  input  wire logic                 i_frame_end,
  input  wire logic                 i_subst_ok,
  output logic [7:0]                o_tx_data,
  output logic                      o_tx_is_k,
  output logic                      o_tx_valid,
  // Control outputs
  output logic                      o_serial_link_enable,
  output logic [7:0]                o_channel_power_down,
  output logic                      o_irq
);
  // ==========================================================
  // Reset release
  logic rst_s1_q;
  logic rst_n;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_s1_q <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n    <= rst_s1_q;
    end
  end

  // ==========================================================
  // Pin synchronisers
  logic sync_s1_q;
  logic sync_s2_q;
  logic pll_s1_q;
  logic pll_s2_q;

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_s1_q <= 1'b0;
      sync_s2_q <= 1'b0;
      pll_s1_q  <= 1'b0;
      pll_s2_q  <= 1'b0;
    end else begin
      sync_s1_q <= i_sync_n;
      sync_s2_q <= sync_s1_q;
      pll_s1_q  <= i_pll_locked;
      pll_s2_q  <= pll_s1_q;
    end
  end

  // ==========================================================
  // Address decode
  wire logic hit_eof;
  wire logic hit_status;
  wire logic hit_pd;
  wire logic hit_mask;
  wire logic hit_ctrl;
  wire logic wr_eof;
  wire logic wr_status;
  wire logic wr_pd;
  wire logic wr_mask;
  wire logic wr_ctrl;

  assign hit_eof    = i_addr == `OFS_EOF_CHAR_SEL;
  assign hit_status = i_addr == `OFS_LINK_STATUS;
  assign hit_pd     = i_addr == `OFS_CHAN_PWR_DOWN;
  assign hit_mask   = i_addr == `OFS_IRQ_MASK;
  assign hit_ctrl   = i_addr == `OFS_LINK_CTRL;
  assign wr_eof     = i_wr && hit_eof;
  assign wr_status  = i_wr && hit_status;
  assign wr_pd      = i_wr && hit_pd;
  assign wr_mask    = i_wr && hit_mask;
  assign wr_ctrl    = i_wr && hit_ctrl;

  // ==========================================================
  // Software registers
  logic [7:0]                       eof_reg_q;
  logic [7:0]                       ctrl_q;
  logic [7:0]                       mask_q;
  serial_link_status_pkg::eof_sel_t eof_sel;
  wire logic                        mode_8b10b;

  // Reserved upper bits of the frame character register are kept as storage
  assign eof_sel    = serial_link_status_pkg::eof_sel_t'(eof_reg_q[1:0]);
  assign mode_8b10b = ctrl_q[`BIT_MODE_8B10B];

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      eof_reg_q            <= `RST_EOF_CHAR_SEL;
      o_channel_power_down <= `RST_CHAN_PWR_DOWN;
      mask_q               <= `RST_IRQ_MASK;
      ctrl_q               <= `RST_LINK_CTRL;
    end else begin
      if (wr_eof) begin
        eof_reg_q <= i_wdata;
      end
      if (wr_pd) begin
        o_channel_power_down <= i_wdata;
      end
      if (wr_mask) begin
        mask_q <= i_wdata;
      end
      if (wr_ctrl) begin
        ctrl_q <= i_wdata;
      end
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_serial_link_enable <= 1'b0;
    end else if (wr_ctrl) begin
      o_serial_link_enable <= i_wdata[`BIT_LINK_ENABLE];
    end
  end

  // ==========================================================
  // Status bits
  logic link_up_q;
  logic realigned_q;
  logic phase_set_q;
  logic arm_q;
  wire logic enable_rise;
  wire logic clr_realigned;
  wire logic clr_phase_set;

  assign enable_rise   = wr_ctrl && i_wdata[`BIT_LINK_ENABLE] && !o_serial_link_enable;
  assign clr_realigned = wr_status && i_wdata[`BIT_REALIGNED];
  assign clr_phase_set = wr_status && i_wdata[`BIT_LMFC_PHASE_SET];

  // Set wins over a clearing write in the same cycle
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      link_up_q   <= 1'b0;
      realigned_q <= 1'b0;
      phase_set_q <= 1'b0;
      arm_q       <= 1'b0;
    end else begin
      link_up_q   <= i_link_up;
      realigned_q <= (realigned_q && !clr_realigned) || i_sysref_realign;
      phase_set_q <= (phase_set_q && !clr_phase_set) || (arm_q && i_sysref_event);
      // Armed from enable until the first SYSREF event
      arm_q       <= enable_rise || (arm_q && !i_sysref_event);
    end
  end

  // Live bits come from hardware only; writes cannot reach them
  wire logic [7:0] status_word;
  assign status_word = {1'b0, link_up_q, sync_s2_q, realigned_q,
                        phase_set_q, pll_s2_q, 2'b00};

  // ==========================================================
  // Read port and interrupt
  wire logic [7:0] rd_mux;
  wire logic [7:0] pending;

  assign rd_mux = hit_eof    ? eof_reg_q :
                  hit_status ? status_word :
                  hit_pd     ? o_channel_power_down :
                  hit_mask   ? mask_q :
                  hit_ctrl   ? {ctrl_q[7:1], o_serial_link_enable} : 8'h00;
  assign pending = {3'b000, realigned_q, phase_set_q, 3'b000} & mask_q;

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_rdata <= 8'h00;
      o_irq   <= 1'b0;
    end else begin
      o_rdata <= i_rd ? rd_mux : 8'h00;
      o_irq   <= |pending;
    end
  end

  // ==========================================================
  // Frame character insertion
  eof_char_inserter u_eof (
    .i_clk        (i_clk),
    .i_rst_n      (rst_n),
    .i_sel        (eof_sel),
    .i_mode_8b10b (mode_8b10b),
    .i_data       (i_tx_data),
    .i_valid      (i_tx_valid),
    .i_frame_end  (i_frame_end),
    .i_subst_ok   (i_subst_ok),
    .o_data       (o_tx_data),
    .o_is_k       (o_tx_is_k),
    .o_valid      (o_tx_valid)
  );

  // ==========================================================
  // Assertions
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!rst_n);

  property p_eof_char;
    i_tx_valid && i_frame_end && i_subst_ok && mode_8b10b |=>
      o_tx_is_k && o_tx_data == serial_link_status_pkg::eof_char($past(eof_sel));
  endproperty
  a_eof_char: assert property (p_eof_char) else $error("wrong end-of-frame comma");

  property p_no_subst;
    i_tx_valid && !(i_frame_end && i_subst_ok) |=>
      !o_tx_is_k && o_tx_data == $past(i_tx_data);
  endproperty
  a_no_subst: assert property (p_no_subst) else $error("octet replaced without cause");

  property p_mode_ignore;
    i_tx_valid && !mode_8b10b |=> !o_tx_is_k && o_tx_data == $past(i_tx_data);
  endproperty
  a_mode_ignore: assert property (p_mode_ignore) else $error("comma in 64b/66b mode");

  property p_link_up_read;
    i_rd && hit_status |=> o_rdata[`BIT_LINK_UP] == $past(i_link_up, 2);
  endproperty
  a_link_up_read: assert property (p_link_up_read) else $error("link up bit stale");

  property p_sync_read;
    i_rd && hit_status |=> o_rdata[`BIT_SYNC_LEVEL] == $past(i_sync_n, 3);
  endproperty
  a_sync_read: assert property (p_sync_read) else $error("sync level bit wrong");

  property p_realign_set;
    i_sysref_realign ##1 !clr_realigned ##1 (i_rd && hit_status) |=> o_rdata[`BIT_REALIGNED];
  endproperty
  a_realign_set: assert property (p_realign_set) else $error("realign not flagged");

  property p_realign_clear;
    clr_realigned && !i_sysref_realign |=> !realigned_q;
  endproperty
  a_realign_clear: assert property (p_realign_clear) else $error("realign not cleared");

  property p_phase_set;
    arm_q && i_sysref_event |=> phase_set_q && !arm_q;
  endproperty
  a_phase_set: assert property (p_phase_set) else $error("phase flag not set");

  property p_phase_only_armed;
    !arm_q && !phase_set_q |=> !phase_set_q;
  endproperty
  a_phase_only_armed: assert property (p_phase_only_armed) else $error("phase flag unarmed");

  property p_pll_read;
    i_rd && hit_status |=> o_rdata[`BIT_PLL_LOCKED] == $past(i_pll_locked, 3);
  endproperty
  a_pll_read: assert property (p_pll_read) else $error("pll lock bit wrong");

  property p_live_write;
    (wr_status && i_wdata[`BIT_LINK_UP] && !i_link_up) ##1 (i_rd && hit_status)
      |=> !o_rdata[`BIT_LINK_UP];
  endproperty
  a_live_write: assert property (p_live_write) else $error("write reached link up bit");

  property p_irq;
    realigned_q && mask_q[`BIT_REALIGNED] |=> o_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt missing");

  property p_realign_wins;
    i_sysref_realign |=> realigned_q;
  endproperty
  a_realign_wins: assert property (p_realign_wins) else $error("realign lost to clear");

  property p_irq_quiet;
    !(|pending) |=> !o_irq;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet) else $error("interrupt without cause");

  property p_rdata_idle;
    !i_rd |=> o_rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read");

  c_comma:   cover property (o_tx_is_k);
  c_phase:   cover property (enable_rise ##[1:20] (arm_q && i_sysref_event));
  c_set_clr: cover property (clr_realigned && i_sysref_realign);
  c_irq:     cover property (o_irq ##1 !o_irq);
endmodule
`default_nettype wire

/* logic/serial_link_status_consts.svh */
// Register offsets, field positions and reset values of the link status bank
`ifndef SERIAL_LINK_STATUS_CONSTS_SVH
`define SERIAL_LINK_STATUS_CONSTS_SVH

// ==========================================================
// Register offsets
`define ADDR_W              12
`define OFS_EOF_CHAR_SEL    12'h207
`define OFS_LINK_STATUS     12'h208
`define OFS_CHAN_PWR_DOWN   12'h209
`define OFS_IRQ_MASK        12'h2f0
`define OFS_LINK_CTRL       12'h2f1

// ==========================================================
// Field positions
`define BIT_LINK_UP         6
`define BIT_SYNC_LEVEL      5
`define BIT_REALIGNED       4
`define BIT_LMFC_PHASE_SET  3
`define BIT_PLL_LOCKED      2
`define BIT_LINK_ENABLE     0
`define BIT_MODE_8B10B      1

// ==========================================================
// Reset values
`define RST_EOF_CHAR_SEL    8'h00
`define RST_CHAN_PWR_DOWN   8'h00
`define RST_IRQ_MASK        8'h00
`define RST_LINK_CTRL       8'h02

// ==========================================================
// Comma octets (K28.7, K28.1, K28.5)
`define OCTET_K28_7         8'hfc
`define OCTET_K28_1         8'h3c
`define OCTET_K28_5         8'hbc

`endif

/* logic/serial_link_status_pkg.sv */
// Types and shared decode for the link status bank
package serial_link_status_pkg;
  `include "serial_link_status_consts.svh"

  typedef logic [7:0] reg_byte_t;

  typedef enum logic [1:0] {
    EOF_K28_7,
    EOF_K28_1,
    EOF_K28_5,
    EOF_RESERVED
  } eof_sel_t;

  // Reserved code falls back to the compliant character
  function automatic reg_byte_t eof_char(input eof_sel_t sel);
    case (sel)
      EOF_K28_1: eof_char = `OCTET_K28_1;
      EOF_K28_5: eof_char = `OCTET_K28_5;
      default:   eof_char = `OCTET_K28_7;
    endcase
  endfunction
endpackage

/* logic/eof_char_inserter.sv */
// Registered end-of-frame comma substitution on the transmit octet stream
`timescale 1ns/10ps
`default_nettype none
module eof_char_inserter (
  // Clock and reset
  input  wire logic                             i_clk,
  input  wire logic                             i_rst_n,
  // Configuration
  input  wire serial_link_status_pkg::eof_sel_t i_sel,
  input  wire logic                             i_mode_8b10b,
  // Octet stream in
  input  wire logic [7:0]                       i_data,
  input  wire logic                             i_valid,
  input  wire logic                             i_frame_end,
  input  wire logic                             i_subst_ok,
  // Octet stream out
  output logic [7:0]                            o_data,
  output logic                                  o_is_k,
  output logic                                  o_valid
);
  wire logic       take_comma;
  wire logic [7:0] next_octet;

  // Only a frame end whose data allows it gets the comma
  assign take_comma = i_valid && i_frame_end && i_subst_ok && i_mode_8b10b;
  assign next_octet = take_comma ? serial_link_status_pkg::eof_char(i_sel) : i_data;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_data  <= 8'h00;
      o_is_k  <= 1'b0;
      o_valid <= 1'b0;
    end else begin
      o_data  <= next_octet;
      o_is_k  <= take_comma;
      o_valid <= i_valid;
    end
  end
endmodule
`default_nettype wire

/* dv/link_rx_model.sv */
// Behavioural far-end receiver: drives SYNC~ and counts received commas
`timescale 1ns/10ps
`default_nettype none
module link_rx_model #(
  parameter int unsigned LAG = 2
) (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  // Control from bench
  input  wire logic       i_hold_sync,
  // Octet stream from device
  input  wire logic [7:0] i_tx_data,
  input  wire logic       i_tx_is_k,
  input  wire logic       i_tx_valid,
  // Link side outputs
  output logic            o_sync_n,
  output logic [7:0]      o_comma_cnt
);
  logic [3:0] lag_q;

  // ==========================================================
  // SYNC~ held low on request, released LAG+1 cycles later
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lag_q    <= 4'h0;
      o_sync_n <= 1'b0;
    end else if (i_hold_sync) begin
      lag_q    <= 4'h0;
      o_sync_n <= 1'b0;
    end else if (lag_q < LAG[3:0]) begin
      lag_q <= lag_q + 4'h1;
    end else begin
      o_sync_n <= 1'b1;
    end
  end

  // ==========================================================
  // Any of the three commas is accepted as frame end
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_comma_cnt <= 8'h00;
    end else if (i_tx_valid && i_tx_is_k && (i_tx_data == 8'hfc || i_tx_data == 8'h3c
                 || i_tx_data == 8'hbc)) begin
      o_comma_cnt <= o_comma_cnt + 8'h01;
    end
  end
endmodule
`default_nettype wire

/* dv/tb_serial_link_status_and_frame_char.sv */
// Self-checking bench for the link status and frame character bank
`timescale 1ns/10ps
`default_nettype none
`include "serial_link_status_consts.svh"
module tb_serial_link_status_and_frame_char;
  logic        clk, arst_n, wr, rd, sync_n, pll, link_up, realign, sysevt, hold_sync;
  logic        txv, fe, ok, tx_k, tx_v, lnk_en, irq;
  logic [11:0] addr;
  logic [7:0]  wdata, rdata, txd, tx_o, pwr_dn, commas, v, d;
  int          err_total, cmp_count;
  logic [11:0] ra [5] = '{`OFS_EOF_CHAR_SEL, `OFS_CHAN_PWR_DOWN, `OFS_IRQ_MASK,
                          `OFS_LINK_CTRL, `OFS_LINK_STATUS};
  logic [7:0]  rv [5] = '{8'h00, 8'h00, 8'h00, 8'h02, 8'h00};

  serial_link_status_and_frame_char DUT (
    .i_clk(clk), .i_arst_n(arst_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .i_sync_n(sync_n), .i_pll_locked(pll),
    .i_link_up(link_up), .i_sysref_realign(realign), .i_sysref_event(sysevt),
    .i_tx_data(txd), .i_tx_valid(txv), .i_frame_end(fe), .i_subst_ok(ok),
    .o_tx_data(tx_o), .o_tx_is_k(tx_k), .o_tx_valid(tx_v),
    .o_serial_link_enable(lnk_en), .o_channel_power_down(pwr_dn), .o_irq(irq));

  link_rx_model #(.LAG(2)) rx (
    .i_clk(clk), .i_rst_n(arst_n), .i_hold_sync(hold_sync), .i_tx_data(tx_o),
    .i_tx_is_k(tx_k), .i_tx_valid(tx_v), .o_sync_n(sync_n), .o_comma_cnt(commas));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ==========================================================
  // Expectations and checking
  function automatic logic [7:0] comma(input logic [1:0] s);
    case (s)
      2'h1: comma = 8'h3c;
      2'h2: comma = 8'hbc;
      default: comma = 8'hfc;
    endcase
  endfunction

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr8(input logic [11:0] a, input logic [7:0] dat);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= dat;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask

  // Write then read back to back on one address
  task automatic wrrd(input logic [11:0] a, input logic [7:0] dat, output logic [7:0] got);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= dat;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    got = rdata;
  endtask

  task automatic rd8(input logic [11:0] a, output logic [7:0] dat);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    dat = rdata;
  endtask

  task automatic st(input logic [7:0] exp);
    rd8(`OFS_LINK_STATUS, v);
    chk("status", v, exp);
  endtask

  task automatic pulse(input bit evt);
    @(posedge clk);
    if (evt) sysevt <= 1'b1;
    else realign <= 1'b1;
    @(posedge clk);
    sysevt <= 1'b0;
    realign <= 1'b0;
  endtask

  task automatic tx(input logic f, input logic k, input logic xk, input logic [7:0] xd);
    @(posedge clk);
    txd <= d;
    txv <= 1'b1;
    fe <= f;
    ok <= k;
    @(posedge clk);
    txv <= 1'b0;
    #1;
    chk("tx data", tx_o, xd);
    chk("tx comma flag", {7'h0, tx_k}, {7'h0, xk});
    chk("tx valid", {7'h0, tx_v}, 8'h01);
  endtask

  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Run is about 270 cycles; a hang is cut well past that
  initial begin
    #100000;
    err_total++;
    complete_run();
  end

  // ==========================================================
  // Main sequence
  initial begin
    {arst_n, wr, rd, pll, link_up, realign, sysevt, txv, fe, ok} = '0;
    hold_sync = 1'b1;
    addr = 12'h000;
    wdata = 8'h00;
    txd = 8'h00;
    err_total = 0;
    cmp_count = 0;
    void'($urandom(32'h554d5306));
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    foreach (ra[i]) begin
      rd8(ra[i], v);
      chk("reset value", v, rv[i]);
    end
    for (int i = 0; i < 8; i++) begin
      d = 8'($urandom);
      wr8(`OFS_EOF_CHAR_SEL, d);
      rd8(`OFS_EOF_CHAR_SEL, v);
      chk("eof select", v, d);
      wrrd(`OFS_CHAN_PWR_DOWN, ~d, v);
      chk("power down", v, ~d);
      chk("power down pins", pwr_dn, ~d);
    end
    wr8(12'h300, 8'h5a);
    rd8(12'h300, v);
    chk("unmapped", v, 8'h00);
    // Live bits follow inputs and ignore writes
    for (int i = 0; i < 8; i++) begin
      d = 8'($urandom);
      @(posedge clk);
      link_up <= d[0];
      pll <= d[1];
      hold_sync <= d[2];
      repeat (8) @(posedge clk);
      wrrd(`OFS_LINK_STATUS, 8'hff, v);
      chk("status live", v, {1'b0, d[0], ~d[2], 2'b00, d[1], 2'b00});
    end
    @(posedge clk);
    link_up <= 1'b1;
    pll <= 1'b1;
    hold_sync <= 1'b0;
    repeat (8) @(posedge clk);
    // Sticky realign bit and its interrupt
    pulse(1'b0);
    st(8'h74);
    chk("irq masked", {7'h0, irq}, 8'h00);
    wr8(`OFS_IRQ_MASK, 8'h10);
    repeat (2) @(posedge clk);
    #1;
    chk("irq raised", {7'h0, irq}, 8'h01);
    wr8(`OFS_LINK_STATUS, 8'h10);
    repeat (2) @(posedge clk);
    #1;
    chk("irq cleared", {7'h0, irq}, 8'h00);
    st(8'h64);
    // Set and clear in one cycle: the set wins
    @(posedge clk);
    wr <= 1'b1;
    addr <= `OFS_LINK_STATUS;
    wdata <= 8'h10;
    realign <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    realign <= 1'b0;
    st(8'h74);
    wr8(`OFS_LINK_STATUS, 8'h10);
    st(8'h64);
    // Phase flag only on the first event after enabling
    pulse(1'b1);
    st(8'h64);
    wr8(`OFS_LINK_CTRL, 8'h03);
    chk("link enable", {7'h0, lnk_en}, 8'h01);
    pulse(1'b1);
    st(8'h6c);
    wr8(`OFS_IRQ_MASK, 8'h08);
    repeat (2) @(posedge clk);
    #1;
    chk("irq phase", {7'h0, irq}, 8'h01);
    wr8(`OFS_LINK_STATUS, 8'h08);
    pulse(1'b1);
    st(8'h64);
    // Frame character changed only with the link disabled
    wr8(`OFS_LINK_CTRL, 8'h02);
    chk("link disable", {7'h0, lnk_en}, 8'h00);
    for (int s = 0; s < 4; s++) begin
      wr8(`OFS_EOF_CHAR_SEL, 8'(s));
      d = 8'($urandom);
      tx(1'b1, 1'b1, 1'b1, comma(s[1:0]));
      tx(1'b1, 1'b0, 1'b0, d);
      tx(1'b0, 1'b1, 1'b0, d);
    end
    wr8(`OFS_LINK_CTRL, 8'h00);
    tx(1'b1, 1'b1, 1'b0, d);
    chk("commas seen", commas, 8'h04);
    @(posedge clk);
    #1;
    chk("tx idle", {7'h0, tx_v}, 8'h00);
    complete_run();
  end
endmodule
`default_nettype wire
